/* File: testbench/swds_sysref_src.sv */
// External SYSREF source model for the window bench
`timescale 1ns/1ps
module swds_sysref_src (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Source control
    input  wire logic       en_i,
    input  wire logic [7:0] period_i,
    // SYSREF output
    output logic            sysref_o
);
    logic [7:0] cnt;

    // Periodic SYSREF, high for the first half of each period, low when stopped
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            cnt      <= 8'h00;
            sysref_o <= 1'b0;
        end else begin
            cnt      <= (cnt == period_i - 8'h01) ? 8'h00 : cnt + 8'h01;
            sysref_o <= (cnt < (period_i >> 1));
        end
    end
endmodule // swds_sysref_src

/* File: testbench/sysref_window_detect_select_bench.sv */
// Self-checking bench for the SYSREF capture window block
`timescale 1ns/1ps
module sysref_window_detect_select_bench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, en = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o, q;
    logic        ack, sref, cap, smp, sref_d = 1'b0;
    int          failures = 0, n_checks = 0, rises = 0, caps = 0, smps = 0;
    int          seed = 32'ha6b0, c0, m_ctrl, m_sel, m_win, m_lo, m_hi, m_pick;

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    swds_sysref_window #(.DIV(8)) swds_sysref_window_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .sysref_i(sref),
        .sysref_capture_o(cap), .sample_en_o(smp));

    swds_sysref_src swds_sysref_src_i (
        .clk_i(clk_i), .rst_i(rst_i), .en_i(en), .period_i(8'd80),
        .sysref_o(sref));

    // Event counters for pin edges and output pulses
    always @(posedge clk_i) begin
        sref_d <= sref;
        if (sref && !sref_d) rises <= rises + 1;
        if (cap === 1'b1) caps <= caps + 1;
        if (smp === 1'b1) smps <= smps + 1;
    end

    task summarize;
        if (failures == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s exp %h got %h", nm, e, s);
        end
    endtask

    // Classic single Wishbone cycle, held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 50);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 50) begin
            failures++;
            summarize();
        end
        @(posedge clk_i);
    endtask

    task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 4'hf, 32'h0);
        chk(nm, e, q);
    endtask

    // Wait for n more SYSREF rises at the pin, then 70 clocks, until SYSREF and all fine-spaced taps are low
    task wait_rises(input int n);
        int t, k;
        t = rises + n;
        k = 0;
        while (rises < t && k < 2000) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 2000) begin
            failures++;
            summarize();
        end
        repeat (70) @(posedge clk_i);
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 3; i++) rd("pos", 8'(8'hb0 + 4 * i), 32'hff);
        rd("ctrl", 8'hc0, 32'h0);
        rd("stat", 8'hc4, 32'h0);
        rd("unmapped", 8'h00, 32'h0);
        wb(1'b1, 8'hb0, 4'hf, 32'h0);
        rd("pos_ro", 8'hb0, 32'hff);
        wb(1'b1, 8'hc0, 4'h0, 32'h1f);
        rd("ctrl_nosel", 8'hc0, 32'h0);
        // four-bit tap select, fine step bit
        m_sel = $random(seed) & 32'hf;
        m_ctrl = m_sel | 32'h10;
        wb(1'b1, 8'hc0, 4'h1, 32'hffffffc0 | m_ctrl);
        rd("ctrl", 8'hc0, m_ctrl);
        en <= 1'b1;
        wait_rises(2);
        rd("stat2", 8'hc4, 32'h2 | (m_sel << 4));
        rd("pos2", 8'hb4, 32'hff);
        wait_rises(1);
        rd("stat3", 8'hc4, 32'h7 | (m_sel << 4));
        // end positions always flagged, upper bits clear
        wb(1'b0, 8'hb0, 4'hf, 32'h0);
        chk("pos_low", 32'h1, q & 32'hffffff01);
        m_win = q;
        wb(1'b0, 8'hb4, 4'hf, 32'h0);
        chk("pos_mid", 32'h0, q & 32'hffffff00);
        m_win = m_win | (q << 8);
        wb(1'b0, 8'hb8, 4'hf, 32'h0);
        chk("pos_high", 32'h80, q & 32'hffffff80);
        // middle of the lowest clean run among positions 0 to 15
        m_lo = 16;
        m_hi = 15;
        for (int b = 15; b >= 0; b--) begin
            if (!m_win[b]) m_lo = b;
        end
        for (int b = 15; b > 0; b--) begin
            if (b > m_lo && m_win[b]) m_hi = b - 1;
        end
        m_pick = (m_lo > 15) ? 0 : (m_lo + m_hi) / 2;
        wb(1'b1, 8'hc0, 4'h1, m_pick | 32'h10);
        wait_rises(1);
        rd("stat_pick", 8'hc4, 32'h7 | (m_pick << 4));
        c0 = caps;
        wait_rises(2);
        chk("captures", 2, caps - c0);
        c0 = smps;
        repeat (80) @(posedge clk_i);
        chk("samples_dual", 10, smps - c0);
        wb(1'b1, 8'hc0, 4'h1, m_ctrl | 32'h20);
        c0 = smps;
        repeat (80) @(posedge clk_i);
        chk("samples_single", 20, smps - c0);
        // coarse steps for the slow clock, tap select zero from next edge
        wb(1'b1, 8'hc0, 4'h1, 32'h0);
        wait_rises(1);
        rd("stat_sel0", 8'hc4, 32'h7);
        // Mid-run reset drops validity
        rst_i <= 1'b1;
        en <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("pos_rst", 8'hb8, 32'hff);
        rd("stat_rst", 8'hc4, 32'h0);
        summarize();
    end
endmodule // sysref_window_detect_select_bench

/* File: verilog/swds_cfg.svh */
// Constants for the capture window detect and tap select block
// Function
// - SYSREF is captured on a fixed device clock edge so that latency repeats at every start.
// - In single-channel mode both device clock edges are used for sampling.
// - The capture offset is measured against the rising edge and reported as 24 bits, lowest delay byte at lowest address.
// - The position status is not valid until at least three SYSREF rising edges have been seen.
// - A status bit reads 1 for a position with a possible setup or hold violation and 0 for a good one.
// - SYSREF is captured at the position whose index equals the tap select value.
// - Tap select reaches positions 0 to 15 only; bits 16 to 23 are for information.
// - Status bits 0 and 23 always read 1.
// - Step bit 0 gives coarse tap spacing and 1 gives fine spacing.
// - Dual-channel mode samples on rising edges only, single-channel mode on both edges.
`ifndef SWDS_CFG_SVH
`define SWDS_CFG_SVH

// Register indices, byte address is four times the index
`define SWDS_IDX_POS_LOW   6'h2c
`define SWDS_IDX_POS_MID   6'h2d
`define SWDS_IDX_POS_HIGH  6'h2e
`define SWDS_IDX_CTRL      6'h30
`define SWDS_IDX_STAT      6'h31

// Control register fields
`define SWDS_CTRL_SEL_LSB  0
`define SWDS_CTRL_SEL_MSB  3
`define SWDS_CTRL_FINE_BIT 4
`define SWDS_CTRL_DES_BIT  5

// Reset values
`define SWDS_SEL_RST       4'h0
`define SWDS_POS_RST       24'hffffff
`define SWDS_POS_ENDS      24'h800001

// Sizes and counts
`define SWDS_NUM_TAPS      24
`define SWDS_MIN_EDGES     2'h3
`define SWDS_DEVCLK_DIV    8

`endif

/* File: verilog/swds_pkg.sv */
// Types shared by the capture window block
package swds_pkg;
    typedef logic [23:0] swds_pos_t;
    typedef logic [3:0]  swds_sel_t;
    typedef logic [1:0]  swds_edge_cnt_t;
endpackage

/* File: verilog/swds_sysref_window.sv */
// SYSREF capture window detector, tap select and register slave
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "swds_cfg.svh"
module swds_sysref_window #(
    parameter int DIV = `SWDS_DEVCLK_DIV
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // SYSREF pin
    input  wire logic        sysref_i,
    // Capture and sampling outputs
    output logic             sysref_capture_o,
    output logic             sample_en_o
);
    localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;

    // Tap carrier and delay line
    swds_tap_if #(.NT(`SWDS_NUM_TAPS)) tif ();

    swds_tap_line #(.NT(`SWDS_NUM_TAPS)) swds_tap_line_i (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tif   (tif)
    );

    // Transitions between neighbours flag both positions
    function automatic swds_pkg::swds_pos_t edge_flags(input swds_pkg::swds_pos_t v);
        logic [22:0] d;
        d          = v[23:1] ^ v[22:0];
        edge_flags = {d, 1'b0} | {1'b0, d};
    endfunction

    // Control state
    swds_pkg::swds_sel_t      sel_reg;
    swds_pkg::swds_sel_t      sel_active;
    logic                     fine;
    logic                     des;
    // Window measurement
    swds_pkg::swds_pos_t      status;
    swds_pkg::swds_pos_t      work;
    swds_pkg::swds_edge_cnt_t edge_cnt;
    logic                     tap0_q;
    logic                     cap_q;
    // Pin synchroniser
    logic                     sref_meta;
    logic                     sref_sync;
    // Device clock divider
    logic [CW-1:0]            div_cnt;

    // Two stage synchroniser on the pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sref_meta <= 1'b0;
            sref_sync <= 1'b0;
        end else begin
            sref_meta <= sysref_i;
            sref_sync <= sref_meta;
        end
    end

    assign tif.sref = sref_sync;
    assign tif.fine = fine;

    // Device clock period counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt <= '0;
        end else if (div_cnt == CW'(DIV - 1)) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // Edge strobes and derived events
    logic                rise_en;
    logic                fall_en;
    logic                strobe;
    logic                sr_rise;
    logic                valid;
    logic                tap_sel_val;
    swds_pkg::swds_pos_t flags_now;
    swds_pkg::swds_pos_t next_status;

    assign rise_en     = (div_cnt == '0);
    assign fall_en     = (div_cnt == CW'(DIV / 2));
    assign strobe      = rise_en | (des & fall_en);
    assign sr_rise     = tif.taps[0] & ~tap0_q;
    assign valid       = (edge_cnt == `SWDS_MIN_EDGES);
    assign flags_now   = rise_en ? edge_flags(tif.taps) : '0;
    assign next_status = work | flags_now | `SWDS_POS_ENDS;
    assign tap_sel_val = tif.taps[sel_active];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_en_o <= 1'b0;
        end else begin
            sample_en_o <= strobe;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_q            <= 1'b0;
            sysref_capture_o <= 1'b0;
        end else begin
            sysref_capture_o <= strobe & tap_sel_val & ~cap_q;
            if (strobe) begin
                cap_q <= tap_sel_val;
            end
        end
    end

    // tap select taken at SYSREF edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_active <= `SWDS_SEL_RST;
        end else if (sr_rise) begin
            sel_active <= sel_reg;
        end
    end

    // accumulate violation flags per SYSREF period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tap0_q   <= 1'b0;
            work     <= '0;
            edge_cnt <= '0;
            status   <= `SWDS_POS_RST;
        end else begin
            tap0_q <= tif.taps[0];
            if (sr_rise) begin
                work <= flags_now;
                if (!valid) begin
                    edge_cnt <= edge_cnt + 1'b1;
                end
                if (edge_cnt >= 2'h2) begin
                    status <= next_status;
                end
            end else begin
                work <= work | flags_now;
            end
        end
    end

    // Wishbone decode
    logic         req;
    logic [5:0]   idx;
    logic         wr_ctrl;
    logic [31:0]  ctrl_rd;
    logic [31:0]  stat_rd;
    logic [31:0]  rd_mux;

    assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign idx     = wb_adr_i[7:2];
    assign wr_ctrl = req & wb_we_i & wb_sel_i[0] & (idx == `SWDS_IDX_CTRL);
    assign ctrl_rd = {26'h0, des, fine, sel_reg};
    assign stat_rd = {24'h0, sel_active, cap_q, valid, edge_cnt};
    // lowest delay byte at lowest index
    assign rd_mux  = (idx == `SWDS_IDX_POS_LOW)  ? {24'h0, status[7:0]}   :
                     (idx == `SWDS_IDX_POS_MID)  ? {24'h0, status[15:8]}  :
                     (idx == `SWDS_IDX_POS_HIGH) ? {24'h0, status[23:16]} :
                     (idx == `SWDS_IDX_CTRL)     ? ctrl_rd                :
                     (idx == `SWDS_IDX_STAT)     ? stat_rd                : 32'h0;

    // Bus answer, one cycle after the request is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req;
            if (req) begin
                wb_dat_o <= wb_we_i ? 32'h0 : rd_mux;
            end
        end
    end

    // select field holds 0 to 15 only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_reg <= `SWDS_SEL_RST;
            fine    <= 1'b0;
            des     <= 1'b0;
        end else if (wr_ctrl) begin
            sel_reg <= wb_dat_i[`SWDS_CTRL_SEL_MSB:`SWDS_CTRL_SEL_LSB];
            fine    <= wb_dat_i[`SWDS_CTRL_FINE_BIT];
            des     <= wb_dat_i[`SWDS_CTRL_DES_BIT];
        end
    end

    // Checks on the measurement, tap select, capture, sampling and bus answer paths
    property p_ends_set;
        @(posedge clk_i) disable iff (rst_i)
        status[0] && status[23];
    endproperty
    a_ends_set: assert property (p_ends_set) else $error("end positions not flagged");

    property p_invalid_all_set;
        @(posedge clk_i) disable iff (rst_i)
        !valid |-> (status == `SWDS_POS_RST);
    endproperty
    a_invalid_all_set: assert property (p_invalid_all_set) else $error("status early");

    property p_valid_on_edge;
        @(posedge clk_i) disable iff (rst_i)
        $rose(valid) |-> $past(sr_rise) && ($past(edge_cnt) == 2'h2);
    endproperty
    a_valid_on_edge: assert property (p_valid_on_edge) else $error("valid without edge");

    property p_status_publish;
        @(posedge clk_i) disable iff (rst_i)
        sr_rise && valid |=> (status == $past(next_status));
    endproperty
    a_status_publish: assert property (p_status_publish) else $error("status not updated");

    property p_status_hold;
        @(posedge clk_i) disable iff (rst_i)
        !sr_rise |=> $stable(status);
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("status moved off edge");

    property p_sel_apply;
        @(posedge clk_i) disable iff (rst_i)
        sr_rise |=> (sel_active == $past(sel_reg));
    endproperty
    a_sel_apply: assert property (p_sel_apply) else $error("tap select not applied");

    property p_sel_wait;
        @(posedge clk_i) disable iff (rst_i)
        !sr_rise |=> $stable(sel_active);
    endproperty
    a_sel_wait: assert property (p_sel_wait) else $error("tap select changed early");

    property p_cap_tap;
        @(posedge clk_i) disable iff (rst_i)
        strobe |=> (cap_q == $past(tap_sel_val));
    endproperty
    a_cap_tap: assert property (p_cap_tap) else $error("capture used wrong tap");

    property p_cap_pulse;
        @(posedge clk_i) disable iff (rst_i)
        sysref_capture_o |-> cap_q && $past(strobe) ##1 !sysref_capture_o;
    endproperty
    a_cap_pulse: assert property (p_cap_pulse) else $error("capture pulse off edge");

    property p_dual_edge;
        @(posedge clk_i) disable iff (rst_i)
        des && fall_en |=> sample_en_o;
    endproperty
    a_dual_edge: assert property (p_dual_edge) else $error("falling edge not sampled");

    property p_rise_only;
        @(posedge clk_i) disable iff (rst_i)
        !des && !rise_en |=> !sample_en_o;
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("extra sample in dual mode");

    property p_wb_ack;
        @(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("bus answer timing wrong");

    property p_pos_read;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && (idx == `SWDS_IDX_POS_LOW) |=> wb_dat_o == {24'h0, $past(status[7:0])};
    endproperty
    a_pos_read: assert property (p_pos_read) else $error("low status byte wrong");

    // Checks on bus reads, control register, divider, measurement, capture and sampling paths
    property p_high_read;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && (idx == `SWDS_IDX_POS_HIGH) |=>
            wb_dat_o == {24'h0, $past(status[23:16])};
    endproperty
    a_high_read: assert property (p_high_read) else $error("high status byte wrong");

    property p_write_zero;
        @(posedge clk_i) disable iff (rst_i)
        req && wb_we_i |=> (wb_dat_o == 32'h0);
    endproperty
    a_write_zero: assert property (p_write_zero) else $error("write answer data not zero");

    property p_ctrl_write;
        @(posedge clk_i) disable iff (rst_i)
        wr_ctrl |=> (sel_reg == $past(wb_dat_i[`SWDS_CTRL_SEL_MSB:`SWDS_CTRL_SEL_LSB]))
            && (fine == $past(wb_dat_i[`SWDS_CTRL_FINE_BIT]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_ctrl_hold;
        @(posedge clk_i) disable iff (rst_i)
        !wr_ctrl |=> $stable(sel_reg) && $stable(fine) && $stable(des);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without write");

    property p_div_range;
        @(posedge clk_i) disable iff (rst_i)
        div_cnt <= CW'(DIV - 1);
    endproperty
    a_div_range: assert property (p_div_range) else $error("divider out of range");

    property p_work_restart;
        @(posedge clk_i) disable iff (rst_i)
        sr_rise |=> (work == $past(flags_now));
    endproperty
    a_work_restart: assert property (p_work_restart) else $error("window not restarted");

    property p_valid_stays;
        @(posedge clk_i) disable iff (rst_i)
        valid |=> valid;
    endproperty
    a_valid_stays: assert property (p_valid_stays) else $error("valid dropped");

    property p_cap_on_rise;
        @(posedge clk_i) disable iff (rst_i)
        $rose(cap_q) |-> sysref_capture_o;
    endproperty
    a_cap_on_rise: assert property (p_cap_on_rise) else $error("capture pulse missing");

    property p_rise_sample;
        @(posedge clk_i) disable iff (rst_i)
        rise_en |=> sample_en_o;
    endproperty
    a_rise_sample: assert property (p_rise_sample) else $error("rising edge not sampled");
endmodule // swds_sysref_window

/* File: verilog/swds_tap_if.sv */
// Carrier between the window logic and the tap delay line
`timescale 1ns/1ps
interface swds_tap_if #(
    parameter int NT = 24
);
    logic [NT-1:0] taps;
    logic          fine;
    logic          sref;

    modport line (input fine, input sref, output taps);
    modport user (output fine, output sref, input taps);
endinterface // swds_tap_if

/* File: verilog/swds_tap_line.sv */
// Delay line giving delayed samples of SYSREF at coarse or fine spacing
`timescale 1ns/1ps
module swds_tap_line #(
    parameter int NT = 24
) (
    // Clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    // Tap carrier
    swds_tap_if.line   tif
);
    logic [2*NT-1:0] line;

    // Shift the synchronised SYSREF in, newest sample at index 0
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line <= '0;
        end else begin
            line <= {line[2*NT-2:0], tif.sref};
        end
    end

    genvar k;
    generate
        for (k = 0; k < NT; k++) begin : g_tap
            assign tif.taps[k] = tif.fine ? line[k] : line[2*k];
        end
    endgenerate

    property p_coarse_step;
        @(posedge clk_i) disable iff (rst_i)
        !tif.fine |-> (tif.taps[1] == line[2]) && (tif.taps[NT-1] == line[2*NT-2]);
    endproperty
    a_coarse_step: assert property (p_coarse_step) else $error("coarse tap spacing wrong");

    property p_fine_step;
        @(posedge clk_i) disable iff (rst_i)
        tif.fine && $past(tif.fine) |-> (tif.taps[2] == $past(tif.taps[1]));
    endproperty
    a_fine_step: assert property (p_fine_step) else $error("fine tap spacing wrong");
endmodule // swds_tap_line
